// ===== core/lcd_pkg.sv
package lcd_pkg;
  // Serial word layout
  localparam int WORD_BITS      = 8;
  localparam int CODE_BITS      = 7;
  localparam int CODE_MSB       = 7;
  localparam int CODE_LSB       = 1;
  localparam int SEL_BIT        = 0;
  localparam logic SEL_RED      = 1'h0;
  localparam logic SEL_IR       = 1'h1;
  localparam logic [6:0] CODE_RESET = 7'h00;
  localparam logic [6:0] CODE_MAX   = 7'h7f;
  // Pin idle levels: select and cancel enable high, rest low
  localparam logic [5:0] SYNC_INIT  = 6'h21;

  // Output arrangement
  typedef enum logic {
    LCD_BRIDGE   = 1'b0,
    LCD_PUSHPULL = 1'b1
  } lcd_mode_t;

  // Serial port phase
  typedef enum logic [1:0] {
    LCD_IDLE  = 2'b00,
    LCD_SHIFT = 2'b01
  } lcd_state_t;

  // One LED's pin drive
  typedef struct packed {
    logic level;
    logic enable;
  } lcd_pin_t;

  // Latched current settings
  typedef struct packed {
    logic [6:0] red;
    logic [6:0] ir;
  } lcd_codes_t;
endpackage

// ===== core/lcd_led_current_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - Red and infrared select inputs each switch one LED, active high.
// - Each LED current set by its own 7-bit code written serially.
// - Codes 0 to 127 accepted; current scales linearly with code.
// - Bridge: both low floats outputs; one high drives that side high.
// - Both selects high drive both outputs high; in bridge, no LED current.
// - One 8-bit shift latch plus red and infrared 7-bit registers.
// - Words sent MSB first; select bit 0 arrives last.
// - Serial bits accepted only while chip select is low.
// - One data bit sampled on each serial clock rising edge.
// - Chip select rising copies latch into register chosen by bit 0.
// - Bits 7..1 carry current code, bit 0 selects register.
// - Bridge drive or two independent push-pull drives supported.
// - With cancellation on, conversion pauses while no LED is lit.
// - Cancellation enable low gives continuous conversion; high enables.
module lcd_led_current_ctrl (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             clkEn,
  input  wire lcd_pkg::lcd_mode_t driveMode,
  input  wire logic             serialSelN,
  input  wire logic             serialClk,
  input  wire logic             serialData,
  input  wire logic             redLedSelect,
  input  wire logic             infraredLedSelect,
  input  wire logic             ambientCancelEnable,
  output logic [6:0]            redCurrentCode,
  output logic [6:0]            infraredCurrentCode,
  output logic                  redDriveOutput,
  output logic                  redDriveEnable,
  output logic                  infraredDriveOutput,
  output logic                  infraredDriveEnable,
  output logic                  converterRun,
  output logic                  codesUpdated
);

  // Two-flop synchronisers for pins, third flop for edge detection
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pinMeta_r;
  logic [NSYNC-1:0] pinMeta_nxt;
  logic [NSYNC-1:0] pinSync_r;
  logic [NSYNC-1:0] pinSync_nxt;
  logic [NSYNC-1:0] pinPrev_r;
  logic [NSYNC-1:0] pinPrev_nxt;
  logic [NSYNC-1:0] pinIn;

  assign pinIn = {serialSelN, serialClk, serialData, redLedSelect,
                  infraredLedSelect, ambientCancelEnable};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : gSync
      always_comb begin
        pinMeta_nxt[gi] = pinIn[gi];
        pinSync_nxt[gi] = pinMeta_r[gi];
        pinPrev_nxt[gi] = pinSync_r[gi];
      end

      // Reset to each pin's idle level: no false edge or LED pulse
      always_ff @(posedge clk) begin
        if (srst) begin
          pinMeta_r[gi] <= lcd_pkg::SYNC_INIT[gi];
          pinSync_r[gi] <= lcd_pkg::SYNC_INIT[gi];
          pinPrev_r[gi] <= lcd_pkg::SYNC_INIT[gi];
        end else if (clkEn) begin
          pinMeta_r[gi] <= pinMeta_nxt[gi];
          pinSync_r[gi] <= pinSync_nxt[gi];
          pinPrev_r[gi] <= pinPrev_nxt[gi];
        end
      end
    end
  endgenerate

  logic selN;
  logic sclkRise;
  logic sdata;
  logic redSel;
  logic irSel;
  logic cancelEn;
  logic selRise;
  logic selFall;

  assign selN     = pinSync_r[5];
  assign sclkRise = pinSync_r[4] & ~pinPrev_r[4];
  assign sdata    = pinSync_r[3];
  assign redSel   = pinSync_r[2];
  assign irSel    = pinSync_r[1];
  assign cancelEn = pinSync_r[0];
  assign selRise  = selN & ~pinPrev_r[5];
  assign selFall  = ~selN & pinPrev_r[5];

  // Serial port: latch and two stored settings
  lcd_pkg::lcd_state_t state_r;
  lcd_pkg::lcd_state_t state_nxt;
  logic [7:0]          shift_r;
  logic [7:0]          shift_nxt;
  lcd_pkg::lcd_codes_t codes_r;
  lcd_pkg::lcd_codes_t codes_nxt;
  logic                upd_r;
  logic                upd_nxt;

  always_comb begin
    state_nxt  = state_r;
    shift_nxt  = shift_r;
    codes_nxt  = codes_r;
    upd_nxt    = 1'b0;
    case (state_r)
      lcd_pkg::LCD_IDLE: begin
        if (selFall || !selN) begin
          state_nxt  = lcd_pkg::LCD_SHIFT;
        end
      end
      lcd_pkg::LCD_SHIFT: begin
        if (selRise) begin
          state_nxt = lcd_pkg::LCD_IDLE;
          upd_nxt   = 1'b1;
          if (shift_r[lcd_pkg::SEL_BIT] == lcd_pkg::SEL_RED) begin
            codes_nxt.red = shift_r[lcd_pkg::CODE_MSB:lcd_pkg::CODE_LSB];
          end else begin
            codes_nxt.ir = shift_r[lcd_pkg::CODE_MSB:lcd_pkg::CODE_LSB];
          end
        end else if (!selN && sclkRise) begin
          shift_nxt = {shift_r[6:0], sdata};
        end
      end
      default: begin
        state_nxt = lcd_pkg::LCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r  <= lcd_pkg::LCD_IDLE;
      shift_r  <= 8'h00;
      codes_r  <= {lcd_pkg::CODE_RESET, lcd_pkg::CODE_RESET};
      upd_r    <= 1'b0;
    end else if (clkEn) begin
      state_r  <= state_nxt;
      shift_r  <= shift_nxt;
      codes_r  <= codes_nxt;
      upd_r    <= upd_nxt;
    end
  end

  // Full 0..127 range passes to the current DAC unchanged
  assign redCurrentCode      = codes_r.red;
  assign infraredCurrentCode = codes_r.ir;
  assign codesUpdated        = upd_r;

  // LED drive truth table
  lcd_pkg::lcd_pin_t redPin_r;
  lcd_pkg::lcd_pin_t redPin_nxt;
  lcd_pkg::lcd_pin_t irPin_r;
  lcd_pkg::lcd_pin_t irPin_nxt;
  logic              conv_r;
  logic              conv_nxt;

  always_comb begin
    redPin_nxt = '{level: 1'b0, enable: 1'b0};
    irPin_nxt  = '{level: 1'b0, enable: 1'b0};
    if (driveMode == lcd_pkg::LCD_BRIDGE) begin
      case ({redSel, irSel})
        2'b00: begin
          redPin_nxt = '{level: 1'b0, enable: 1'b0};
          irPin_nxt  = '{level: 1'b0, enable: 1'b0};
        end
        2'b10: begin
          redPin_nxt = '{level: 1'b1, enable: 1'b1};
          irPin_nxt  = '{level: 1'b0, enable: 1'b1};
        end
        2'b01: begin
          redPin_nxt = '{level: 1'b0, enable: 1'b1};
          irPin_nxt  = '{level: 1'b1, enable: 1'b1};
        end
        2'b11: begin
          redPin_nxt = '{level: 1'b1, enable: 1'b1};
          irPin_nxt  = '{level: 1'b1, enable: 1'b1};
        end
        default: begin
          redPin_nxt = '{level: 1'b0, enable: 1'b0};
          irPin_nxt  = '{level: 1'b0, enable: 1'b0};
        end
      endcase
    end else begin
      // Independent push-pull: each select drives its own LED
      redPin_nxt = '{level: redSel, enable: 1'b1};
      irPin_nxt  = '{level: irSel, enable: 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      redPin_r <= '{level: 1'b0, enable: 1'b0};
      irPin_r  <= '{level: 1'b0, enable: 1'b0};
    end else if (clkEn) begin
      redPin_r <= redPin_nxt;
      irPin_r  <= irPin_nxt;
    end
  end

  // Conversion runs only while exactly one LED lit, unless disabled
  always_comb begin
    conv_nxt = !cancelEn || (redSel ^ irSel);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      conv_r <= 1'b0;
    end else if (clkEn) begin
      conv_r <= conv_nxt;
    end
  end

  assign redDriveOutput      = redPin_r.level;
  assign redDriveEnable      = redPin_r.enable;
  assign infraredDriveOutput = irPin_r.level;
  assign infraredDriveEnable = irPin_r.enable;
  assign converterRun        = conv_r;

endmodule

// ===== tb/lcd_props.sv
`timescale 1ns/1ps
module lcd_props (
  input wire logic               clk,
  input wire logic               srst,
  input wire logic               clkEn,
  input wire lcd_pkg::lcd_mode_t driveMode,
  input wire logic               serialSelN,
  input wire logic               redLedSelect,
  input wire logic               infraredLedSelect,
  input wire logic               ambientCancelEnable,
  input wire logic [6:0]         redCurrentCode,
  input wire logic [6:0]         infraredCurrentCode,
  input wire logic               redDriveOutput,
  input wire logic               redDriveEnable,
  input wire logic               infraredDriveOutput,
  input wire logic               infraredDriveEnable,
  input wire logic               converterRun,
  input wire logic               codesUpdated
);
  logic        br;
  logic [3:0]  pins;
  logic [3:0]  old;
  logic [11:0] hist;
  assign br = driveMode == lcd_pkg::LCD_BRIDGE;
  assign pins = {redDriveOutput, redDriveEnable, infraredDriveOutput,
                 infraredDriveEnable};
  // Mode, cancel and selects as seen three edges back
  assign old = hist[11:8];
  // History follows the design's pipeline, frozen with it
  always_ff @(posedge clk) begin
    if (clkEn) begin
      hist <= {hist[7:0], br, ambientCancelEnable, redLedSelect,
               infraredLedSelect};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !clkEn);
  bridge_off_a:
    assert property (br && old[3] && old[1:0] == 2'h0 |-> !pins[2] && !pins[0])
    else $error("bridge outputs not floating");
  bridge_red_a:
    assert property (br && old[3] && old[1:0] == 2'h2 |-> pins == 4'hd)
    else $error("bridge red drive wrong");
  bridge_ir_a:
    assert property (br && old[3] && old[1:0] == 2'h1 |-> pins == 4'h7)
    else $error("bridge infrared drive wrong");
  both_high_a:
    assert property (br && old[3] && old[1:0] == 2'h3 |-> pins == 4'hf)
    else $error("both selects high not both driven high");
  push_pull_a:
    assert property (!br && !old[3] |-> pins == {old[1], 1'h1, old[0], 1'h1})
    else $error("push-pull drive wrong");
  conv_run_a:
    assert property (converterRun == (!old[2] || (old[1] ^ old[0])))
    else $error("converter run wrong");
  code_hold_a:
    assert property (!codesUpdated |-> $stable(redCurrentCode)
                     && $stable(infraredCurrentCode))
    else $error("code changed without update");
  update_time_a:
    assert property ($rose(serialSelN) |-> ##[2:6] codesUpdated)
    else $error("no update after select rise");
  one_pulse_a:
    assert property (codesUpdated |=> !codesUpdated)
    else $error("update pulse longer than one cycle");
  idle_port_a:
    assert property (serialSelN [*8] |-> !codesUpdated)
    else $error("update while port idle");
  cover property (codesUpdated);
  cover property (br && old[1:0] == 2'h3);
  cover property (!br && old[1:0] == 2'h2);
endmodule
bind lcd_led_current_ctrl lcd_props u_lcd_props (
  .clk, .srst, .clkEn, .driveMode, .serialSelN, .redLedSelect,
  .infraredLedSelect,
  .ambientCancelEnable, .redCurrentCode, .infraredCurrentCode,
  .redDriveOutput, .redDriveEnable, .infraredDriveOutput,
  .infraredDriveEnable, .converterRun, .codesUpdated
);

// ===== tb/lcd_host.sv
`timescale 1ns/1ps
module lcd_host (
  input  wire logic clk,
  output logic      serialSelN,
  output logic      serialClk,
  output logic      serialData
);
  initial begin
    serialSelN = 1'h1;
    serialClk = 1'h0;
    serialData = 1'h0;
  end
  // Top n bits of w, first bit first; serial clock idles low
  task automatic send(input logic [7:0] w, input int n);
    @(negedge clk) serialSelN <= 1'h0;
    for (int i = 0; i < n; i++) begin
      serialData <= w[7-i];
      repeat (4) @(negedge clk);
      serialClk <= 1'h1;
      repeat (4) @(negedge clk);
      serialClk <= 1'h0;
    end
    serialData <= ~serialData;
    repeat (4) @(negedge clk);
    serialSelN <= 1'h1;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] word;
    logic [1:0] sel;
    logic [6:0] expRed;
    logic [6:0] expIr;
    logic [6:0] expPin;
  } lcd_row_t;
  logic               clk = 1'h0;
  logic               srst = 1'h1;
  lcd_pkg::lcd_mode_t driveMode = lcd_pkg::LCD_BRIDGE;
  logic               redLedSelect = 1'h0;
  logic               infraredLedSelect = 1'h0;
  logic               ambientCancelEnable = 1'h1;
  logic               clkEn = 1'h1;
  logic               serialSelN, serialClk, serialData;
  logic [6:0]         redCurrentCode, infraredCurrentCode, pinVec;
  logic               redDriveOutput, redDriveEnable, converterRun;
  logic               infraredDriveOutput, infraredDriveEnable, codesUpdated;
  int                 fails = 0;
  int                 numChecks = 0;
  lcd_row_t           rows [6];
  assign pinVec = {2'h0, redDriveOutput & redDriveEnable, redDriveEnable,
                   infraredDriveOutput & infraredDriveEnable,
                   infraredDriveEnable, converterRun};
  lcd_host u_lcd_host (.clk, .serialSelN, .serialClk, .serialData);
  lcd_led_current_ctrl u_lcd_led_current_ctrl (
    .clk, .srst, .clkEn, .driveMode, .serialSelN, .serialClk,
    .serialData, .redLedSelect, .infraredLedSelect, .ambientCancelEnable,
    .redCurrentCode, .infraredCurrentCode, .redDriveOutput,
    .redDriveEnable, .infraredDriveOutput, .infraredDriveEnable,
    .converterRun, .codesUpdated
  );
  always #10 clk = ~clk;
  task automatic chk(input string name, input logic [6:0] e, g);
    numChecks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic word(input logic [7:0] w, input int n);
    int k;
    u_lcd_host.send(w, n);
    for (k = 0; k < 20 && codesUpdated !== 1'h1; k++)
      @(negedge clk);
    if (k == 20) begin
      fails++;
      close_out();
    end
  endtask
  initial begin
    rows = '{'{8'hff, 2'h0, 7'h00, 7'h7f, 7'h00},
             '{8'hfe, 2'h2, 7'h7f, 7'h7f, 7'h1b},
             '{8'h2a, 2'h0, 7'h15, 7'h7f, 7'h00},
             '{8'hab, 2'h1, 7'h15, 7'h55, 7'h0f},
             '{8'h00, 2'h3, 7'h00, 7'h55, 7'h1e},
             '{8'h81, 2'h0, 7'h00, 7'h40, 7'h00}};
    repeat (20) @(negedge clk);
    srst = 1'h0;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      {redLedSelect, infraredLedSelect} = rows[i].sel;
      word(rows[i].word, 8);
      chk("red code", rows[i].expRed, redCurrentCode);
      chk("ir code", rows[i].expIr, infraredCurrentCode);
      chk("pins", rows[i].expPin, pinVec);
      repeat (2500) @(negedge clk);
    end
    srst = 1'h1;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    @(negedge clk);
    chk("reset red", 7'h00, redCurrentCode);
    chk("reset ir", 7'h00, infraredCurrentCode);
    chk("reset pins", 7'h00, pinVec | {codesUpdated, 6'h00});
    word(8'h7e, 8);
    word(8'h90, 4);
    chk("short word", 7'h74, infraredCurrentCode);
    chk("red kept", 7'h3f, redCurrentCode);
    ambientCancelEnable = 1'h0;
    repeat (4) @(negedge clk);
    chk("free run", 7'h01, pinVec);
    driveMode = lcd_pkg::LCD_PUSHPULL;
    redLedSelect = 1'h1;
    repeat (4) @(negedge clk);
    chk("push pull", 7'h1b, pinVec);
    clkEn = 1'h0;
    redLedSelect = 1'h0;
    infraredLedSelect = 1'h1;
    repeat (6) @(negedge clk);
    chk("frozen pins", 7'h1b, pinVec);
    clkEn = 1'h1;
    repeat (4) @(negedge clk);
    chk("thawed pins", 7'h0f, pinVec);
    close_out();
  end
endmodule
